// >>> core/iae_consts.svh
// Offsets, level field width, reset values, event code spacing and pin and source counts of the interrupt accept block
`ifndef IAE_CONSTS_SVH
`define IAE_CONSTS_SVH
`define IAE_OFF_PRIO_A 8'h00
`define IAE_OFF_PRIO_E 8'h04
`define IAE_OFF_EDGE_MODE 8'h08
`define IAE_OFF_PIN_FLAGS 8'h0c
`define IAE_OFF_EVT_CODE 8'h10
`define IAE_OFF_EVT_CODE_TWO 8'h14
`define IAE_OFF_STATUS 8'h18
`define IAE_RST_PRIO 32'h0000_0000
`define IAE_RST_EDGE 4'h0
`define IAE_RST_CODE 12'h000
`define IAE_CODE_BASE 12'h200
`define IAE_CODE_STEP 12'h020
`define IAE_NUM_PIN 4
`define IAE_NUM_SRC 8
`define IAE_LVL_W 4
`define IAE_RESP_OKAY 2'b00
`define IAE_RESP_SLVERR 2'b10
`endif

// >>> core/iae_pkg.sv
// Types of the interrupt accept block
package iae_pkg;
   typedef logic [3:0] iae_level_t;
   typedef logic [2:0] iae_index_t;
   typedef logic [11:0] iae_code_t;
   typedef logic [7:0] iae_req_t;
endpackage

// >>> core/iae_accept.sv
// Interrupt acceptance: arbitration, mask compare, pending pin and event codes
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "iae_consts.svh"
module iae_accept
   import iae_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] ext_irq_pin_n,
   input wire iae_pkg::iae_req_t module_req,
   input wire iae_pkg::iae_level_t interrupt_mask_level,
   input wire logic exception_block_bit,
   input wire logic cpu_irq_take,
   output logic cpu_irq_req,
   output iae_pkg::iae_level_t cpu_irq_level,
   output logic irq_pending_out_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import iae_pkg::*;

   logic [31:0] priority_setting_reg_a;
   logic [31:0] priority_setting_reg_e;
   logic [3:0] edge_mode_reg;
   logic [3:0] pin0_request_flag;
   iae_code_t event_code_reg;
   iae_code_t event_code_reg_two;
   logic [3:0] pin_meta_reg;
   logic [3:0] pin_sync_reg;
   logic [3:0] pin_last_reg;
   iae_req_t req_reg;
   iae_level_t best_level_reg;
   iae_index_t best_idx_reg;
   iae_code_t cpu_code_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic do_write;
   logic [3:0] flag_clear;
   logic [3:0] pin_fell;
   iae_level_t best_level_next;
   iae_index_t best_idx_next;
   logic [31:0] prio_a_merged;
   logic [31:0] prio_e_merged;

   // Programmed level of source i; pins sit in register a, modules in e
   function automatic iae_level_t src_level(input logic [31:0] pa, input logic [31:0] pe,
                                            input int i);
      logic [31:0] r;
      r = (i < `IAE_NUM_PIN) ? pa : pe;
      return r[(i % `IAE_NUM_PIN) * `IAE_LVL_W +: `IAE_LVL_W];
   endfunction

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Event code of a source index; the spacing lets the handler branch on it
   function automatic iae_code_t code_of(input iae_index_t idx);
      return `IAE_CODE_BASE + 12'(`IAE_CODE_STEP * idx);
   endfunction

   assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign flag_clear = (do_write && waddr_reg == `IAE_OFF_PIN_FLAGS && wstrb_reg[0]) ?
                       (~wdata_reg[3:0] & edge_mode_reg) : 4'h0;
   assign pin_fell = pin_last_reg & ~pin_sync_reg;

   // Strobe merge ahead of the registers; a function result cannot be part-selected
   assign prio_a_merged = merge_strb(priority_setting_reg_a, wdata_reg, wstrb_reg);
   assign prio_e_merged = merge_strb(priority_setting_reg_e, wdata_reg, wstrb_reg);

   // Pin synchroniser; the first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_reg <= 4'hf;
         pin_sync_reg <= 4'hf;
         pin_last_reg <= 4'hf;
      end else begin
         pin_meta_reg <= ext_irq_pin_n;
         pin_sync_reg <= pin_meta_reg;
         pin_last_reg <= pin_sync_reg;
      end
   end

   // Pin flags: edge mode latches until software writes 0, set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin0_request_flag <= 4'h0;
      end else begin
         for (int i = 0; i < `IAE_NUM_PIN; i++) begin
            if (edge_mode_reg[i]) begin
               if (pin_fell[i]) begin
                  pin0_request_flag[i] <= 1'b1;
               end else if (flag_clear[i]) begin
                  pin0_request_flag[i] <= 1'b0;
               end
            end else begin
               pin0_request_flag[i] <= ~pin_sync_reg[i];
            end
         end
      end
   end

   // Request sample stage; module requests come from this clock and need no sync
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_reg <= 8'h00;
      end else begin
         req_reg <= {module_req[7:4], pin0_request_flag};
      end
   end

   // Arbitration: strictly greater replaces, so on a tie the lower index stays
   always_comb begin
      best_level_next = 4'h0;
      best_idx_next = 3'h0;
      for (int i = 0; i < `IAE_NUM_SRC; i++) begin
         if (req_reg[i] && src_level(priority_setting_reg_a, priority_setting_reg_e, i) >
             best_level_next) begin
            best_level_next = src_level(priority_setting_reg_a, priority_setting_reg_e, i);
            best_idx_next = 3'(i);
         end
      end
   end

   // Losers are not stored anywhere, they simply stay asserted in req_reg
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         best_level_reg <= 4'h0;
         best_idx_reg <= 3'h0;
      end else begin
         best_level_reg <= best_level_next;
         best_idx_reg <= best_idx_next;
      end
   end

   // Mask compare; the block bit is deliberately not an input of this logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_irq_req <= 1'b0;
         irq_pending_out_n <= 1'b1;
         cpu_irq_level <= 4'h0;
         cpu_code_reg <= `IAE_RST_CODE;
      end else begin
         cpu_irq_req <= best_level_reg > interrupt_mask_level;
         irq_pending_out_n <= !(best_level_reg > interrupt_mask_level);
         cpu_irq_level <= best_level_reg;
         cpu_code_reg <= code_of(best_idx_reg);
      end
   end

   // Event codes load when the CPU takes the request at its boundary
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_code_reg <= `IAE_RST_CODE;
         event_code_reg_two <= `IAE_RST_CODE;
      end else if (cpu_irq_take && cpu_irq_req) begin
         event_code_reg <= cpu_code_reg;
         event_code_reg_two <= cpu_code_reg;
      end
   end

   // Write channels: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IAE_RESP_OKAY;
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (waddr_reg)
               `IAE_OFF_PRIO_A, `IAE_OFF_PRIO_E, `IAE_OFF_EDGE_MODE,
               `IAE_OFF_PIN_FLAGS: s_axi_bresp <= `IAE_RESP_OKAY;
               default: s_axi_bresp <= `IAE_RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Writable configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         priority_setting_reg_a <= `IAE_RST_PRIO;
         priority_setting_reg_e <= `IAE_RST_PRIO;
         edge_mode_reg <= `IAE_RST_EDGE;
      end else if (do_write) begin
         case (waddr_reg)
            `IAE_OFF_PRIO_A: priority_setting_reg_a <= {16'h0000, prio_a_merged[15:0]};
            `IAE_OFF_PRIO_E: priority_setting_reg_e <= {16'h0000, prio_e_merged[15:0]};
            `IAE_OFF_EDGE_MODE: begin
               if (wstrb_reg[0]) begin
                  edge_mode_reg <= wdata_reg[3:0];
               end
            end
            default: ;
         endcase
      end
   end

   // Read channel: one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `IAE_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `IAE_RESP_OKAY;
         case (s_axi_araddr)
            `IAE_OFF_PRIO_A: s_axi_rdata <= priority_setting_reg_a;
            `IAE_OFF_PRIO_E: s_axi_rdata <= priority_setting_reg_e;
            `IAE_OFF_EDGE_MODE: s_axi_rdata <= {28'h0000000, edge_mode_reg};
            `IAE_OFF_PIN_FLAGS: s_axi_rdata <= {28'h0000000, pin0_request_flag};
            `IAE_OFF_EVT_CODE: s_axi_rdata <= {20'h00000, event_code_reg};
            `IAE_OFF_EVT_CODE_TWO: s_axi_rdata <= {20'h00000, event_code_reg_two};
            `IAE_OFF_STATUS: s_axi_rdata <= {16'h0000, req_reg, cpu_irq_req, best_idx_reg,
                                             best_level_reg};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `IAE_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Checks; helper flags test each request against the chosen winner
   logic hlp_no_higher;
   logic hlp_tie_ok;
   always_comb begin
      hlp_no_higher = 1'b1;
      hlp_tie_ok = 1'b1;
      for (int i = 0; i < `IAE_NUM_SRC; i++) begin
         if (req_reg[i] && src_level(priority_setting_reg_a, priority_setting_reg_e, i) >
             best_level_next) begin
            hlp_no_higher = 1'b0;
         end
         if (req_reg[i] && 3'(i) < best_idx_next && best_level_next != 4'h0 &&
             src_level(priority_setting_reg_a, priority_setting_reg_e, i) == best_level_next) begin
            hlp_tie_ok = 1'b0;
         end
      end
   end

   sequence s_edge_pin_fall(int k);
      edge_mode_reg[k] && pin_fell[k];
   endsequence

   sequence s_flag_to_req(int k);
      pin0_request_flag[k] ##1 req_reg[k];
   endsequence

   a_winner_highest: assert property (@(posedge aclk) disable iff (!aresetn)
      hlp_no_higher) else $error("lower level chosen over a higher request");
   a_tie_low_index: assert property (@(posedge aclk) disable iff (!aresetn)
      hlp_tie_ok) else $error("tie not resolved to lowest index");
   a_accept_over_mask: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 (cpu_irq_req == ($past(best_level_reg) > $past(interrupt_mask_level))))
      else $error("CPU request does not match level versus mask");
   a_pin_low_accept: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_pending_out_n == !cpu_irq_req) else $error("pending pin disagrees with accept");
   a_pin_masked_high: assert property (@(posedge aclk) disable iff (!aresetn)
      (best_level_reg <= interrupt_mask_level) |=> irq_pending_out_n)
      else $error("pending pin stayed low while masked");
   a_pin_block_free: assert property (@(posedge aclk) disable iff (!aresetn)
      ($stable(best_level_reg) && $stable(interrupt_mask_level) && $changed(exception_block_bit))
      |=> $stable(irq_pending_out_n)) else $error("pending pin moved with block bit");
   a_code_both_load: assert property (@(posedge aclk) disable iff (!aresetn)
      (cpu_irq_take && cpu_irq_req) |=> (event_code_reg == $past(cpu_code_reg)) &&
      (event_code_reg_two == $past(cpu_code_reg))) else $error("event codes not loaded");
   a_edge_to_accept: assert property (@(posedge aclk) disable iff (!aresetn)
      s_edge_pin_fall(2) |=> s_flag_to_req(2)) else $error("pin edge not latched");
   a_edge_flag_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      (edge_mode_reg[2] && pin0_request_flag[2] && !flag_clear[2]) |=> pin0_request_flag[2])
      else $error("edge flag dropped without a clear");
   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid [*1] ##0 !aw_held_reg) else $error("write not answered");
endmodule
`default_nettype wire

// >>> verification/iae_cpu_model.sv
// CPU-side model that takes signalled requests at instruction boundaries
`timescale 1ns/1ps
`default_nettype none
module iae_cpu_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cpu_irq_req,
   input wire logic take_en,
   input wire logic [2:0] instr_len,
   input wire logic [3:0] sw_mask,
   input wire logic sw_bl_clr,
   output logic cpu_irq_take,
   output logic [3:0] interrupt_mask_level,
   output logic exception_block_bit
);
   logic [2:0] cnt_reg;
   logic [31:0] pc_reg;
   logic [31:0] spc_reg;
   logic [4:0] ssr_reg;
   logic boundary;
   // A boundary only once the running instruction's states are used up
   assign boundary = (cnt_reg == 3'h0);
   always_ff @(posedge aclk) begin
      if (!aresetn || boundary) begin
         cnt_reg <= instr_len;
      end else begin
         cnt_reg <= cnt_reg - 3'h1;
      end
   end
   // Mask moves only by software, never on entry
   always_ff @(posedge aclk) begin
      interrupt_mask_level <= aresetn ? sw_mask : 4'h0;
   end
   // Entry saves state, blocks further entry and jumps; vector base taken as zero
   always_ff @(posedge aclk) begin
      cpu_irq_take <= 1'b0;
      if (!aresetn) begin
         exception_block_bit <= 1'b0;
         pc_reg <= 32'h0000_0000;
         spc_reg <= 32'h0000_0000;
         ssr_reg <= 5'h00;
      end else if (boundary && cpu_irq_req && !exception_block_bit && take_en) begin
         cpu_irq_take <= 1'b1;
         exception_block_bit <= 1'b1;
         ssr_reg <= {exception_block_bit, interrupt_mask_level};
         spc_reg <= pc_reg;
         pc_reg <= 32'h0000_0600;
      end else begin
         pc_reg <= pc_reg + 32'h2;
         if (sw_bl_clr) begin
            exception_block_bit <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the interrupt accept block
`timescale 1ns/1ps
`default_nettype none
`include "iae_consts.svh"
module testbench;
   import iae_pkg::*;
   typedef struct {
      logic [15:0] prio;
      logic [3:0] req;
      logic [3:0] mask;
      logic acc;
      logic [3:0] lvl;
      logic [2:0] idx;
   } iae_row_s;
   // Priority E value, module requests, mask, then expected accept, level, index
   iae_row_s rows [6] = '{
      '{16'h4321, 4'hf, 4'h0, 1'b1, 4'h4, 3'h7},
      '{16'h4321, 4'h7, 4'h0, 1'b1, 4'h3, 3'h6},
      '{16'h4321, 4'h7, 4'h3, 1'b0, 4'h3, 3'h6},
      '{16'h5555, 4'ha, 4'h4, 1'b1, 4'h5, 3'h5},
      '{16'h5555, 4'ha, 4'h5, 1'b0, 4'h5, 3'h5},
      '{16'hf000, 4'h8, 4'he, 1'b1, 4'hf, 3'h7}};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] ext_irq_pin_n = 4'hf;
   iae_req_t module_req = 8'h00;
   iae_level_t interrupt_mask_level;
   logic exception_block_bit, cpu_irq_take, cpu_irq_req, irq_pending_out_n;
   iae_level_t cpu_irq_level;
   logic take_en = 1'b0;
   logic sw_bl_clr = 1'b0;
   logic [3:0] sw_mask = 4'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   int n_errors = 0;
   int total_checks = 0;
   iae_accept DUT (.aclk(aclk), .aresetn(aresetn), .ext_irq_pin_n(ext_irq_pin_n),
      .module_req(module_req), .interrupt_mask_level(interrupt_mask_level),
      .exception_block_bit(exception_block_bit), .cpu_irq_take(cpu_irq_take),
      .cpu_irq_req(cpu_irq_req), .cpu_irq_level(cpu_irq_level),
      .irq_pending_out_n(irq_pending_out_n), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   iae_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .cpu_irq_req(cpu_irq_req),
      .take_en(take_en), .instr_len(3'h3), .sw_mask(sw_mask), .sw_bl_clr(sw_bl_clr),
      .cpu_irq_take(cpu_irq_take), .interrupt_mask_level(interrupt_mask_level),
      .exception_block_bit(exception_block_bit));
   // 25 MHz clock
   always #20 aclk = ~aclk;
   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   // Both write channels offered together; each released once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && k < 50);
      s_axi_bready <= 1'b0;
      chk(s_axi_bvalid === 1'b1 && s_axi_bresp === er, "write response");
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && k < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      chk(s_axi_rvalid === 1'b1, "read answer");
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Bounded wait for the pending pin, then compare
   task automatic wait_pin(input logic v, input int lim);
      int k;
      k = 0;
      while (irq_pending_out_n !== v && k < lim) begin
         @(posedge aclk);
         k++;
      end
      chk(irq_pending_out_n === v, "pending pin level");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(irq_pending_out_n === 1'b1 && cpu_irq_req === 1'b0, "reset outputs");
      axi_rd(`IAE_OFF_PRIO_A, rd, rs);
      chk(rd === 32'h0 && rs === `IAE_RESP_OKAY, "priority reset value");
      axi_rd(8'h1c, rd, rs);
      chk(rd === 32'h0 && rs === `IAE_RESP_SLVERR, "unmapped read");
      axi_wr(8'h1c, 32'hffff_ffff, `IAE_RESP_SLVERR);
      axi_wr(`IAE_OFF_EVT_CODE, 32'h1, `IAE_RESP_SLVERR);
      foreach (rows[i]) begin
         axi_wr(`IAE_OFF_PRIO_E, {16'h0, rows[i].prio}, `IAE_RESP_OKAY);
         module_req <= {rows[i].req, 4'h0};
         sw_mask <= rows[i].mask;
         repeat (6) @(posedge aclk);
         chk(cpu_irq_req === rows[i].acc, "accept decision");
         chk(cpu_irq_level === rows[i].lvl, "winner level");
         chk(irq_pending_out_n === !rows[i].acc, "pending pin");
         axi_rd(`IAE_OFF_STATUS, rd, rs);
         if (rows[i].acc) chk(rd[7:0] === {1'b1, rows[i].idx, rows[i].lvl}, "winner");
      end
      // Edge request on pin 2, taken by the CPU, cleared by software
      module_req <= 8'h00;
      sw_mask <= 4'h0;
      axi_wr(`IAE_OFF_EDGE_MODE, 32'h4, `IAE_RESP_OKAY);
      axi_wr(`IAE_OFF_PRIO_A, 32'h600, `IAE_RESP_OKAY);
      take_en <= 1'b1;
      ext_irq_pin_n <= 4'hb;
      repeat (3) @(posedge aclk);
      ext_irq_pin_n <= 4'hf;
      wait_pin(1'b0, 20);
      repeat (12) @(posedge aclk);
      chk(exception_block_bit === 1'b1 && irq_pending_out_n === 1'b0, "latched");
      axi_rd(`IAE_OFF_EVT_CODE, rd, rs);
      chk(rd[11:0] === `IAE_CODE_BASE + 2 * `IAE_CODE_STEP, "event code");
      axi_rd(`IAE_OFF_EVT_CODE_TWO, rd, rs);
      chk(rd[11:0] === `IAE_CODE_BASE + 2 * `IAE_CODE_STEP, "event code two");
      axi_wr(`IAE_OFF_PIN_FLAGS, 32'h0, `IAE_RESP_OKAY);
      wait_pin(1'b1, 10);
      sw_bl_clr <= 1'b1;
      take_en <= 1'b0;
      @(posedge aclk);
      sw_bl_clr <= 1'b0;
      // Masking releases the pin; a higher level still gets through
      axi_wr(`IAE_OFF_PRIO_E, 32'h4000, `IAE_RESP_OKAY);
      module_req <= 8'h80;
      wait_pin(1'b0, 8);
      sw_mask <= 4'h4;
      wait_pin(1'b1, 5);
      ext_irq_pin_n <= 4'hb;
      wait_pin(1'b0, 20);
      chk(cpu_irq_level === 4'h6, "nested level");
      sw_mask <= 4'h6;
      wait_pin(1'b1, 5);
      // Reset in mid-run with pin 2 still low; level 0 after reset is never accepted
      aresetn <= 1'b0;
      sw_mask <= 4'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(irq_pending_out_n === 1'b1 && cpu_irq_req === 1'b0, "mid-run reset outputs");
      axi_rd(`IAE_OFF_EDGE_MODE, rd, rs);
      chk(rd === 32'h0 && rs === `IAE_RESP_OKAY, "edge mode after reset");
      axi_rd(`IAE_OFF_PIN_FLAGS, rd, rs);
      chk(rd === 32'h4 && rs === `IAE_RESP_OKAY, "level flag follows pin");
      repeat (4) @(posedge aclk);
      chk(irq_pending_out_n === 1'b1 && cpu_irq_req === 1'b0, "level 0 not accepted");
      tally_and_finish();
   end
endmodule
`default_nettype wire
